// ---- design/fcpb_bank.sv ----
// Fieldbus communication parameter bank with supervision and SAFE_TORQUE_OFF fault
// Summary of operation
// R01: Serial node address holds 1..247, default 127, used after power-up.
// R02: Rate code holds up to 405h, default 102h, used after power-up.
// R03: Connection code holds 6h..9h, default 7h, used after power-up.
// R04: A comm failure raises an alert with handling 0, an error with 1.
// R05: Idle longer than the monitor timeout (up to 20000 ms) is an error; with handling 0 the code raises comm_alert_out instead.
// R06: A monitor timeout of zero disables monitoring; zero is default.
// R07: Network node address holds 0..127, default 0, used after restart.
// R08: Each reply waits the programmed count of 0.5 ms steps, 0..1000.
// R09: The network has one master and every node a distinct address.
// R10: Inversion off keeps target sign; inversion on flips it.
// R11: Direction inversion option set to 1 activates inversion.
// R12: In jog, up moves positive, down negative, mode key leaves jog.
// R13: Losing SAFE_TORQUE_OFF voltage while running disables power, flags error, faults.
// R14: In fault, enabling is refused until SAFE_TORQUE_OFF returns and a reset comes.
// R15: An accepted power-up setting reports that it is active after power-on.
// R16: The monitor timer restarts on each good frame for this node.
`timescale 1ns/100ps
module fcpb_bank #(
   parameter int MS_CYCLES = 25000
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic wr_in,
   input wire logic [11:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out,
   output logic [1:0] wr_status_out,
   output logic wr_done_out,
   input wire logic frame_ok_in,
   input wire logic reply_req_in,
   output logic reply_go_out,
   output logic comm_alert_out,
   output logic comm_error_out,
   output logic [7:0] act_serial_addr_out,
   output logic [15:0] act_rate_out,
   output logic [3:0] act_conn_out,
   output logic [6:0] act_net_addr_out,
   input wire logic dir_invert_in,
   input wire logic signed [31:0] target_in,
   output logic signed [31:0] motion_out,
   input wire logic jog_start_in,
   input wire logic key_up_in,
   input wire logic key_down_in,
   input wire logic key_mode_in,
   output logic jog_active_out,
   output logic [1:0] jog_cmd_out,
   input wire logic sto_ok_in,
   input wire logic enable_req_in,
   input wire logic fault_reset_in,
   output logic power_on_out,
   output logic fault_out,
   output logic [8:0] err_code_out
);
   import fcpb_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FAULT} fcpb_state_e;

   // Stored settings survive srst_in, which stands for a power cycle;
   // they hold the factory values only until the first accepted write.
   logic [15:0] addr_ff = RST_SERIAL_NODE_ADDRESS;
   logic [15:0] rate_ff = RST_TRANSMISSION_RATE;
   logic [15:0] conn_ff = RST_SERIAL_CONNECTION;
   logic [15:0] flt_ff = RST_COMM_FAULT_HANDLING;
   logic [15:0] cwd_ff = RST_CONN_MONITOR_TIMEOUT;
   logic [15:0] net_ff = RST_NETWORK_NODE_ADDRESS;
   logic [15:0] cdt_ff = RST_REPLY_DELAY_TIME;
   logic [15:0] rdata_ff;
   logic [1:0] wr_status_ff;
   logic wr_done_ff;
   logic alert_ff, error_ff;
   logic [7:0] act_addr_ff;
   logic [15:0] act_rate_ff;
   logic [3:0] act_conn_ff;
   logic [6:0] act_net_ff;
   logic signed [31:0] motion_ff;
   logic jog_ff;
   logic [1:0] jog_cmd_ff;
   fcpb_state_e state_ff, nxt_state;
   logic [8:0] err_ff;
   logic boot_ff;

   // Address decode and per-register range checks
   wire sel_addr = (addr_in == OFS_SERIAL_NODE_ADDRESS);
   wire sel_rate = (addr_in == OFS_TRANSMISSION_RATE);
   wire sel_conn = (addr_in == OFS_SERIAL_CONNECTION);
   wire sel_flt = (addr_in == OFS_COMM_FAULT_HANDLING);
   wire sel_cwd = (addr_in == OFS_CONN_MONITOR_TIMEOUT);
   wire sel_net = (addr_in == OFS_NETWORK_NODE_ADDRESS);
   wire sel_cdt = (addr_in == OFS_REPLY_DELAY_TIME);
   wire mapped = sel_addr | sel_rate | sel_conn | sel_flt | sel_cwd |
      sel_net | sel_cdt;
   // R01 address range
   wire ok_addr = (wdata_in >= MIN_SERIAL_NODE_ADDRESS) &&
      (wdata_in <= MAX_SERIAL_NODE_ADDRESS);
   // R02 rate range
   wire ok_rate = (wdata_in <= MAX_TRANSMISSION_RATE);
   // R03 connection range
   wire ok_conn = (wdata_in >= MIN_SERIAL_CONNECTION) &&
      (wdata_in <= MAX_SERIAL_CONNECTION);
   wire ok_flt = (wdata_in <= MAX_COMM_FAULT_HANDLING);
   wire ok_cwd = (wdata_in <= MAX_CONN_MONITOR_TIMEOUT);
   // R07 network address range
   wire ok_net = (wdata_in <= MAX_NETWORK_NODE_ADDRESS);
   wire ok_cdt = (wdata_in <= MAX_REPLY_DELAY_TIME);
   wire in_range = (sel_addr & ok_addr) | (sel_rate & ok_rate) |
      (sel_conn & ok_conn) | (sel_flt & ok_flt) | (sel_cwd & ok_cwd) |
      (sel_net & ok_net) | (sel_cdt & ok_cdt);
   wire deferred = sel_addr | sel_rate | sel_conn | sel_net;
   wire wr_ok = wr_in && in_range;

   // Write answer code
   // R15 power-on notice
   wire [1:0] nxt_wr_status = !mapped ? WR_UNMAPPED :
      !in_range ? WR_OUT_OF_RANGE : deferred ? WR_POWER_ON : WR_SAVED;

   // Read mux; unmapped reads return zero
   wire [15:0] nxt_rdata = sel_addr ? addr_ff : sel_rate ? rate_ff :
      sel_conn ? conn_ff : sel_flt ? flt_ff : sel_cwd ? cwd_ff :
      sel_net ? net_ff : sel_cdt ? cdt_ff : 16'h0000;

   // Stored values; out-of-range writes leave the register untouched.
   // No reset branch: a power cycle must not wipe what was saved.
   always_ff @(posedge ref_clk_in) begin
      if (wr_ok && !srst_in) begin
         if (sel_addr) addr_ff <= wdata_in;
         if (sel_rate) rate_ff <= wdata_in;
         if (sel_conn) conn_ff <= wdata_in;
         if (sel_flt) flt_ff <= wdata_in;
         if (sel_cwd) cwd_ff <= wdata_in;
         if (sel_net) net_ff <= wdata_in;
         if (sel_cdt) cdt_ff <= wdata_in;
      end
   end

   // Bus answer registers
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rdata_ff <= 16'h0000;
         wr_status_ff <= WR_SAVED;
         wr_done_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         wr_status_ff <= wr_in ? nxt_wr_status : wr_status_ff;
         wr_done_ff <= wr_in;
      end
   end

   // Active copies are taken once, the cycle after reset release.
   // Reset stands for power-up here, so later writes wait for the next one.
   // R01 R02 R03 R07 apply at power-up
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         boot_ff <= 1'b1;
         act_addr_ff <= 8'h00;
         act_rate_ff <= 16'h0000;
         act_conn_ff <= 4'h0;
         act_net_ff <= 7'h00;
      end else begin
         boot_ff <= 1'b0;
         if (boot_ff) begin
            act_addr_ff <= addr_ff[7:0];
            act_rate_ff <= rate_ff;
            act_conn_ff <= conn_ff[3:0];
            act_net_ff <= net_ff[6:0];
         end
      end
   end

   // Connection monitor and reply delay timers
   logic mon_exp, dly_exp;
   // R06 zero disables monitor
   wire mon_on = (cwd_ff != 16'h0000);
   // R16 restart on good frame
   // A timeout write also reloads, so turning monitoring off cannot let
   // a pending expiry slip through in the same cycle
   wire mon_load = frame_ok_in || !mon_on || (wr_ok && sel_cwd);
   wire [16:0] mon_ticks = mon_on ? {1'b0, cwd_ff} : 17'h0;

   // R05 ms-paced timeout
   fcpb_tick_timer #(.TICK_CYC(MS_CYCLES)) u_mon (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .load_in(mon_load),
      .ticks_in(mon_ticks),
      .busy_out(),
      .expire_out(mon_exp)
   );

   // R08 half-ms reply steps
   fcpb_tick_timer #(.TICK_CYC(TICK_CYCLES)) u_dly (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .load_in(reply_req_in),
      .ticks_in({1'b0, cdt_ff}),
      .busy_out(),
      .expire_out(dly_exp)
   );

   // Zero delay answers two cycles after the request
   logic reply_ff;
   logic req_zero_ff;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         reply_ff <= 1'b0;
         req_zero_ff <= 1'b0;
      end else begin
         req_zero_ff <= reply_req_in && (cdt_ff == 16'h0000);
         reply_ff <= req_zero_ff || dly_exp;
      end
   end

   // R04 alert or error by handling
   // Sticky until reset; the timeout counts as a comm failure.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         alert_ff <= 1'b0;
         error_ff <= 1'b0;
      end else if (mon_exp) begin
         alert_ff <= alert_ff | !flt_ff[0];
         error_ff <= error_ff | flt_ff[0];
      end
   end

   // R10 R11 target sign inversion
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         motion_ff <= 32'sh0;
      end else begin
         motion_ff <= dir_invert_in ? -target_in : target_in;
      end
   end

   // R12 jog keys: 01 positive, 10 negative
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         jog_ff <= 1'b0;
         jog_cmd_ff <= 2'h0;
      end else begin
         if (key_mode_in) jog_ff <= 1'b0;
         else if (jog_start_in) jog_ff <= 1'b1;
         jog_cmd_ff <= (jog_ff && !key_mode_in) ?
            {key_down_in & ~key_up_in, key_up_in & ~key_down_in} : 2'h0;
      end
   end

   // Power stage state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (enable_req_in && sto_ok_in) nxt_state = ST_RUN;
         end
         ST_RUN: begin
            // R13 SAFE_TORQUE_OFF loss faults
            if (!sto_ok_in) nxt_state = ST_FAULT;
         end
         ST_FAULT: begin
            // R14 reset needs SAFE_TORQUE_OFF back
            if (fault_reset_in && sto_ok_in) nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_ff <= ST_IDLE;
         err_ff <= 9'h000;
      end else begin
         state_ff <= nxt_state;
         // R13 error code shown
         if (state_ff == ST_RUN && !sto_ok_in) err_ff <= STO_ERROR_CODE;
         else if (nxt_state == ST_IDLE && state_ff == ST_FAULT)
            err_ff <= 9'h000;
      end
   end

   logic power_ff;
   logic fault_ff;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         power_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         power_ff <= (nxt_state == ST_RUN);
         fault_ff <= (nxt_state == ST_FAULT);
      end
   end

   assign rdata_out = rdata_ff;
   assign wr_status_out = wr_status_ff;
   assign wr_done_out = wr_done_ff;
   assign reply_go_out = reply_ff;
   assign comm_alert_out = alert_ff;
   assign comm_error_out = error_ff;
   assign act_serial_addr_out = act_addr_ff;
   assign act_rate_out = act_rate_ff;
   assign act_conn_out = act_conn_ff;
   assign act_net_addr_out = act_net_ff;
   assign motion_out = motion_ff;
   assign jog_active_out = jog_ff;
   assign jog_cmd_out = jog_cmd_ff;
   assign power_on_out = power_ff;
   assign fault_out = fault_ff;
   assign err_code_out = err_ff;

   // Checks
   chk_range_reject: assert property (@(posedge ref_clk_in)
      disable iff (srst_in)
      wr_in && sel_addr && !ok_addr |=> addr_ff == $past(addr_ff))
      else $error("out-of-range address write stored"); // R01
   chk_rate_range: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) rate_ff <= MAX_TRANSMISSION_RATE)
      else $error("rate code above limit"); // R02
   chk_conn_range: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) conn_ff >= MIN_SERIAL_CONNECTION &&
      conn_ff <= MAX_SERIAL_CONNECTION)
      else $error("connection code out of range"); // R03
   chk_act_hold: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) !boot_ff && !$past(boot_ff) |->
      $stable(act_addr_ff) && $stable(act_net_ff))
      else $error("active address changed without power-up"); // R01
   chk_fault_select: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) mon_exp && flt_ff[0] |=> error_ff)
      else $error("timeout did not raise error"); // R04
   chk_mon_off: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) !mon_on |-> !mon_exp)
      else $error("timeout with monitoring off"); // R06
   chk_power_note: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) wr_in && sel_rate && ok_rate |=>
      wr_status_out == WR_POWER_ON && wr_done_out)
      else $error("power-on notice missing"); // R15
   chk_invert: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) dir_invert_in |=>
      motion_out == -$past(target_in))
      else $error("inversion not applied"); // R10
   chk_sto_fault: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) state_ff == ST_RUN && !sto_ok_in |=>
      fault_out && !power_on_out && err_code_out == STO_ERROR_CODE)
      else $error("SAFE_TORQUE_OFF loss not handled"); // R13
   chk_fault_stay: assert property (@(posedge ref_clk_in)
      disable iff (srst_in) state_ff == ST_FAULT && !sto_ok_in |=>
      state_ff == ST_FAULT)
      else $error("left fault without SAFE_TORQUE_OFF"); // R14
   cov_fault_exit: cover property (@(posedge ref_clk_in)
      state_ff == ST_FAULT ##1 state_ff == ST_IDLE);
   cov_timeout: cover property (@(posedge ref_clk_in) mon_exp);
   cov_reply: cover property (@(posedge ref_clk_in) reply_go_out);
endmodule : fcpb_bank

// ---- design/fcpb_pkg.sv ----
// Package of offsets, reset values, limits and timing for the parameter bank
package fcpb_pkg;
   localparam logic [11:0] OFS_SERIAL_NODE_ADDRESS = 12'h400;
   localparam logic [11:0] OFS_TRANSMISSION_RATE = 12'h402;
   localparam logic [11:0] OFS_SERIAL_CONNECTION = 12'h404;
   localparam logic [11:0] OFS_COMM_FAULT_HANDLING = 12'h406;
   localparam logic [11:0] OFS_CONN_MONITOR_TIMEOUT = 12'h408;
   localparam logic [11:0] OFS_NETWORK_NODE_ADDRESS = 12'h40a;
   localparam logic [11:0] OFS_REPLY_DELAY_TIME = 12'h40e;
   localparam logic [15:0] RST_SERIAL_NODE_ADDRESS = 16'h007f;
   localparam logic [15:0] RST_TRANSMISSION_RATE = 16'h0102;
   localparam logic [15:0] RST_SERIAL_CONNECTION = 16'h0007;
   localparam logic [15:0] RST_COMM_FAULT_HANDLING = 16'h0000;
   localparam logic [15:0] RST_CONN_MONITOR_TIMEOUT = 16'h0000;
   localparam logic [15:0] RST_NETWORK_NODE_ADDRESS = 16'h0000;
   localparam logic [15:0] RST_REPLY_DELAY_TIME = 16'h0000;
   localparam logic [15:0] MIN_SERIAL_NODE_ADDRESS = 16'h0001;
   localparam logic [15:0] MAX_SERIAL_NODE_ADDRESS = 16'h00f7;
   localparam logic [15:0] MAX_TRANSMISSION_RATE = 16'h0405;
   localparam logic [15:0] MIN_SERIAL_CONNECTION = 16'h0006;
   localparam logic [15:0] MAX_SERIAL_CONNECTION = 16'h0009;
   localparam logic [15:0] MAX_COMM_FAULT_HANDLING = 16'h0001;
   localparam logic [15:0] MAX_CONN_MONITOR_TIMEOUT = 16'h4e20;
   localparam logic [15:0] MAX_NETWORK_NODE_ADDRESS = 16'h007f;
   localparam logic [15:0] MAX_REPLY_DELAY_TIME = 16'h03e8;
   // Write answer codes
   localparam logic [1:0] WR_SAVED = 2'h0;
   localparam logic [1:0] WR_OUT_OF_RANGE = 2'h1;
   localparam logic [1:0] WR_POWER_ON = 2'h2;
   localparam logic [1:0] WR_UNMAPPED = 2'h3;
   localparam logic [8:0] STO_ERROR_CODE = 9'h1f5;
   // Timing: half-ms tick at 25 MHz
   localparam int CLK_HZ = 25000000;
   localparam int TICK_US = 500;
   localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
endpackage : fcpb_pkg

// ---- design/fcpb_tick_timer.sv ----
// Down-counting timer paced in ticks of a fixed cycle count
`timescale 1ns/100ps
module fcpb_tick_timer #(
   parameter int TICK_CYC = 12500
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic load_in,
   input wire logic [16:0] ticks_in,
   output logic busy_out,
   output logic expire_out
);
   logic [16:0] left_ff;
   logic [16:0] nxt_left;
   logic [$clog2(TICK_CYC)-1:0] pre_ff;
   logic [$clog2(TICK_CYC)-1:0] nxt_pre;
   logic pre_wrap;
   logic expire_ff;
   logic nxt_expire;

   // Prescaler wraps once per tick; restarted on load
   assign pre_wrap = (pre_ff == ($clog2(TICK_CYC))'(TICK_CYC - 1));
   assign nxt_pre = (load_in || pre_wrap) ? '0 : pre_ff + 1'b1;
   assign nxt_left = load_in ? ticks_in :
      ((pre_wrap && left_ff != 17'h0) ? left_ff - 17'h1 : left_ff);
   assign nxt_expire = !load_in && pre_wrap && (left_ff == 17'h1);

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         left_ff <= 17'h0;
         pre_ff <= '0;
         expire_ff <= 1'b0;
      end else begin
         left_ff <= nxt_left;
         pre_ff <= nxt_pre;
         expire_ff <= nxt_expire;
      end
   end

   assign busy_out = (left_ff != 17'h0);
   assign expire_out = expire_ff;
endmodule : fcpb_tick_timer

// ---- verif/fcpb_master_model.sv ----
// Bus master model: good frames and reply requests toward the bank
`timescale 1ns/100ps
module fcpb_master_model (
   input wire logic ref_clk_in,
   output logic frame_ok_out,
   output logic reply_req_out
);
   initial begin
      frame_ok_out = 1'b0;
      reply_req_out = 1'b0;
   end
   // sole master
   // Only frames for this node reach the bank, so every frame counts
   task automatic send_frame(input int gap);
      repeat (gap) @(negedge ref_clk_in);
      frame_ok_out = 1'b1;
      @(negedge ref_clk_in);
      frame_ok_out = 1'b0;
   endtask : send_frame
   // Gap lets the master be prompt or slow between requests
   task automatic ask_reply(input int gap);
      repeat (gap) @(negedge ref_clk_in);
      reply_req_out = 1'b1;
      @(negedge ref_clk_in);
      reply_req_out = 1'b0;
   endtask : ask_reply
endmodule : fcpb_master_model

// ---- verif/fcpb_bank_tb.sv ----
// Self-checking bench for the communication parameter bank
`timescale 1ns/100ps
module fcpb_bank_tb;
   import fcpb_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic [11:0] adr = 12'h400;
   logic [15:0] wd = 16'h0000;
   logic [15:0] rd;
   logic [1:0] st;
   logic done, frm, req, go, alrt, cerr, jact, pon, comm_fault_handling;
   logic [7:0] a_ser;
   logic [15:0] a_rate;
   logic [3:0] a_conn;
   logic [6:0] a_net;
   logic [1:0] jcmd;
   logic [8:0] ecode;
   logic inv = 1'b0;
   logic signed [31:0] tgt = 32'sh0;
   logic signed [31:0] mot;
   logic jst = 1'b0, kup = 1'b0, kdn = 1'b0, kmd = 1'b0;
   logic safe_torque_off = 1'b1, enr = 1'b0, frs = 1'b0;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   // Write table: a value just past every range limit, the upper limit except for handling and timeout, and an unmapped offset
   logic [11:0] w_a [15] = '{12'h400, 12'h400, 12'h400, 12'h402, 12'h402,
      12'h404, 12'h404, 12'h404, 12'h406, 12'h408, 12'h40a, 12'h40a,
      12'h40e, 12'h40e, 12'h40c};
   logic [15:0] w_d [15] = '{16'h0000, 16'h00f8, 16'h00f7, 16'h0406,
      16'h0405, 16'h0005, 16'h000a, 16'h0009, 16'h0002, 16'h4e21,
      16'h0080, 16'h007f, 16'h03e9, 16'h03e8, 16'h1234};
   logic [1:0] w_s [15] = '{WR_OUT_OF_RANGE, WR_OUT_OF_RANGE, WR_POWER_ON,
      WR_OUT_OF_RANGE, WR_POWER_ON, WR_OUT_OF_RANGE, WR_OUT_OF_RANGE,
      WR_POWER_ON, WR_OUT_OF_RANGE, WR_OUT_OF_RANGE, WR_OUT_OF_RANGE,
      WR_POWER_ON, WR_OUT_OF_RANGE, WR_SAVED, WR_UNMAPPED};
   // Short ms tick keeps monitor runs brief; half-ms tick stays real
   fcpb_bank #(.MS_CYCLES(10)) dut (.ref_clk_in(clk), .srst_in(srst),
      .wr_in(wr), .addr_in(adr), .wdata_in(wd), .rdata_out(rd),
      .wr_status_out(st), .wr_done_out(done), .frame_ok_in(frm),
      .reply_req_in(req), .reply_go_out(go), .comm_alert_out(alrt),
      .comm_error_out(cerr), .act_serial_addr_out(a_ser),
      .act_rate_out(a_rate), .act_conn_out(a_conn),
      .act_net_addr_out(a_net), .dir_invert_in(inv), .target_in(tgt),
      .motion_out(mot), .jog_start_in(jst), .key_up_in(kup),
      .key_down_in(kdn), .key_mode_in(kmd), .jog_active_out(jact),
      .jog_cmd_out(jcmd), .sto_ok_in(safe_torque_off), .enable_req_in(enr),
      .fault_reset_in(frs), .power_on_out(pon), .fault_out(comm_fault_handling),
      .err_code_out(ecode));
   fcpb_master_model master (.ref_clk_in(clk), .frame_ok_out(frm),
      .reply_req_out(req));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task automatic wr_reg(input logic [11:0] a, input logic [15:0] d,
         input logic [1:0] s);
      @(negedge clk);
      wr = 1'b1;
      adr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
      check(done, 1'b1);
      check(st, s);
   endtask : wr_reg
   task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
      @(negedge clk);
      adr = a;
      @(negedge clk);
      check(rd, e);
   endtask : rd_reg
   // Reset stands in for a power cycle; stored settings take over
   task automatic power_cycle(input int cyc);
      @(negedge clk);
      srst = 1'b1;
      repeat (cyc) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
   endtask : power_cycle
   function automatic logic pick(input int sel);
      case (sel)
         0: return go;
         1: return alrt;
         default: return cerr;
      endcase
   endfunction : pick
   // A bound that runs out counts as a mismatch and ends the run
   task automatic wait_hi(input int sel, input int lim, output int cnt);
      cnt = 0;
      while (pick(sel) !== 1'b1) begin
         @(negedge clk);
         cnt++;
         if (cnt > lim) begin
            err_total++;
            $display("ERROR t=%0t wait bound used up", $time);
            results();
         end
      end
   endtask : wait_hi
   initial begin
      power_cycle(8);
      rd_reg(OFS_SERIAL_NODE_ADDRESS, 16'h007f);
      rd_reg(OFS_TRANSMISSION_RATE, 16'h0102);
      rd_reg(OFS_SERIAL_CONNECTION, 16'h0007);
      rd_reg(OFS_COMM_FAULT_HANDLING, 16'h0000);
      rd_reg(OFS_CONN_MONITOR_TIMEOUT, 16'h0000);
      rd_reg(OFS_NETWORK_NODE_ADDRESS, 16'h0000);
      rd_reg(OFS_REPLY_DELAY_TIME, 16'h0000);
      for (int i = 0; i < 15; i++) begin
         wr_reg(w_a[i], w_d[i], w_s[i]);
      end
      rd_reg(OFS_SERIAL_NODE_ADDRESS, 16'h00f7);
      rd_reg(OFS_SERIAL_CONNECTION, 16'h0009);
      check(a_ser, 8'h7f);
      check(a_rate, 16'h0102);
      check(a_net, 7'h00);
      power_cycle(2);
      check({a_ser, a_rate}, {8'hf7, 16'h0405});
      check({a_conn, a_net}, {4'h9, 7'h7f});
      $display("test registers done");
      // reply delay, zero and one step
      wr_reg(OFS_REPLY_DELAY_TIME, 16'h0000, WR_SAVED);
      master.ask_reply(0);
      wait_hi(0, 4, n);
      check(n, 1);
      wr_reg(OFS_REPLY_DELAY_TIME, 16'h0001, WR_SAVED);
      master.ask_reply(1);
      wait_hi(0, 13000, n);
      check(n > 12490 && n < 12512, 1'b1);
      $display("test reply done");
      wr_reg(OFS_COMM_FAULT_HANDLING, 16'h0000, WR_SAVED);
      wr_reg(OFS_CONN_MONITOR_TIMEOUT, 16'h0000, WR_SAVED);
      repeat (100) @(negedge clk);
      check(alrt, 1'b0);
      wr_reg(OFS_CONN_MONITOR_TIMEOUT, 16'h0002, WR_SAVED);
      for (int i = 0; i < 5; i++) begin
         master.send_frame(14);
      end
      check({alrt, cerr}, 2'b00);
      wait_hi(1, 40, n);
      check(n, 21);
      check(cerr, 1'b0);
      power_cycle(2);
      wr_reg(OFS_COMM_FAULT_HANDLING, 16'h0001, WR_SAVED);
      wr_reg(OFS_CONN_MONITOR_TIMEOUT, 16'h0002, WR_SAVED);
      master.send_frame(0);
      wait_hi(2, 40, n);
      check(alrt, 1'b0);
      $display("test monitor done");
      tgt = 32'sd100;
      repeat (2) @(negedge clk);
      check(mot, 32'sd100);
      inv = 1'b1;
      repeat (2) @(negedge clk);
      check(mot, -32'sd100);
      jst = 1'b1;
      @(negedge clk);
      jst = 1'b0;
      kup = 1'b1;
      repeat (2) @(negedge clk);
      check({jact, jcmd}, 3'b101);
      kup = 1'b0;
      kdn = 1'b1;
      repeat (2) @(negedge clk);
      check(jcmd, 2'b10);
      kdn = 1'b0;
      kmd = 1'b1;
      repeat (2) @(negedge clk);
      kmd = 1'b0;
      check(jact, 1'b0);
      $display("test motion done");
      enr = 1'b1;
      repeat (3) @(negedge clk);
      check(pon, 1'b1);
      safe_torque_off = 1'b0;
      repeat (3) @(negedge clk);
      check({pon, comm_fault_handling, ecode}, {2'b01, STO_ERROR_CODE});
      frs = 1'b1;
      repeat (3) @(negedge clk);
      check({pon, comm_fault_handling}, 2'b01);
      enr = 1'b0;
      safe_torque_off = 1'b1;
      repeat (3) @(negedge clk);
      frs = 1'b0;
      check({pon, comm_fault_handling}, 2'b00);
      enr = 1'b1;
      repeat (3) @(negedge clk);
      check(pon, 1'b1);
      $display("test safe torque off done");
      results();
   end
endmodule : fcpb_bank_tb
